/* File: rtl/spt_pkg.sv */
// Constants, register map and state types of the self polling timer block.
package spt_pkg;
	// Register indices; byte address is four times the index.
	localparam logic [6:0] IX_MODE = 7'h02;
	localparam logic [6:0] IX_CTRL = 7'h03;
	localparam logic [6:0] IX_STAT = 7'h04;
	localparam logic [6:0] IX_MASK = 7'h05;
	localparam logic [6:0] IX_CHAN = 7'h06;
	localparam logic [6:0] IX_PCTL = 7'h07;
	localparam logic [6:0] IX_RTV = 7'h08;
	localparam logic [6:0] IX_OFFL = 7'h09;
	localparam logic [6:0] IX_OFFH = 7'h0A;
	localparam logic [6:0] IX_AP = 7'h0B;
	localparam logic [6:0] IX_IP = 7'h0C;
	localparam logic [6:0] IX_SN0 = 7'h0E;
	localparam logic [6:0] IX_SN1 = 7'h0F;
	localparam logic [6:0] IX_SN2 = 7'h10;
	localparam logic [6:0] IX_ONAL = 7'h1F;
	localparam logic [6:0] IX_ONAH = 7'h20;
	localparam logic [6:0] IX_ONBL = 7'h40;
	localparam logic [6:0] IX_ONBH = 7'h41;
	// Reset values.
	localparam logic [7:0] RST_STAT = 8'hFF;
	localparam logic [7:0] RST_RTV = 8'h01;
	localparam logic [7:0] RST_OFFL = 8'h07;
	localparam logic [4:0] RST_AP = 5'h01;
	localparam logic [7:0] RST_IP = 8'h01;
	localparam logic [7:0] RST_ONL = 8'h01;
	// Field positions.
	localparam int B_SPEN = 0;
	localparam int B_DUAL = 2;
	localparam int B_POL = 5;
	localparam int B_PERM = 3;
	localparam int B_AIEN = 2;
	// Behaviour select codes, timing and bus response codes.
	localparam logic [1:0] SEL_FFB = 2'h1;
	localparam logic [1:0] SEL_MIX = 2'h2;
	localparam logic [5:0] PRE_LAST = 6'h3F;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF, ST_RUN} spt_state_e;

	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_hold;
		logic [6:0] aw_idx;
		logic aw_ok;
		logic w_hold;
		logic [7:0] w_data;
		logic w_en;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [1:0] mode;
		logic pol;
		logic [7:0] status;
		logic [7:0] mask;
		logic [1:0] chan;
		logic [3:0] pctl;
		logic [7:0] rtv;
		logic [13:0] off;
		logic [4:0] ap;
		logic [7:0] ip;
		logic [13:0] on_a;
		logic [13:0] on_b;
		spt_state_e st;
		logic cfg_b;
		logic [5:0] pre;
		logic [7:0] refc;
		logic [13:0] tcnt;
		logic [7:0] aic;
		logic idle;
		logic irq_pin;
		logic rx_on;
		logic search;
		logic fastfb;
	} spt_s;
endpackage : spt_pkg

/* File: rtl/spt_top.sv */
// Self polling timing, wake channel report and interrupt mask block.
//--------------------------------------------------------------------
//--------------------------------------------------------------------
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module spt_top import spt_pkg::*; #(
	parameter logic [23:0] SERIAL_NUMBER = 24'h5A3C96 // Arbitrary value.
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write.
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read.
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Receiver events and wake report.
	input wire logic [7:0] events,
	input wire logic wake_found,
	input wire logic [1:0] wake_chan,
	// Outputs.
	output logic interrupt_out_pin,
	output logic rx_on,
	output logic wake_search,
	output logic fast_fallback,
	output logic active_config_b
);

	//----------------------------------------------------------------
	// Helper functions
	//----------------------------------------------------------------

	// A register index is mapped when it names a known register.
	function automatic logic mapped(input logic [11:0] a);
		logic [6:0] ix;
		ix = a[8:2];
		mapped = (a[11:9] == 3'h0) && (a[1:0] == 2'h0) &&
			(ix inside {IX_MODE, IX_CTRL, IX_STAT, IX_MASK, IX_CHAN,
			IX_PCTL, IX_RTV, IX_OFFL, IX_OFFH, IX_AP, IX_IP, IX_SN0,
			IX_SN1, IX_SN2, IX_ONAL, IX_ONAH, IX_ONBL, IX_ONBH});
	endfunction : mapped

	// Reload value of the on-time for the chosen configuration.
	function automatic logic [13:0] on_load(input spt_s s, input logic b);
		on_load = (b ? s.on_b : s.on_a) - 14'h0001;
	endfunction : on_load

	//----------------------------------------------------------------
	// State
	//----------------------------------------------------------------

	spt_s q;
	spt_s d;
	logic pre_tick;
	logic rt;
	logic [6:0] ar_ix;
	logic [7:0] rmux;
	logic spen;

	assign pre_tick = (q.pre == PRE_LAST);
	assign rt = pre_tick && (q.refc == 8'h00);
	assign ar_ix = araddr[8:2];
	assign spen = q.mode[B_SPEN];

	// Read data mux; write-only settings read back as stored.
	always_comb
	begin
		rmux = 8'h00;
		case (ar_ix)
			IX_MODE: rmux = {5'h00, q.mode[1], 1'b0, q.mode[0]};
			IX_CTRL: rmux = {2'h0, q.pol, 5'h00};
			IX_STAT: rmux = q.status;
			IX_MASK: rmux = q.mask;
			IX_CHAN: rmux = {6'h00, q.chan};
			IX_PCTL: rmux = {4'h0, q.pctl};
			IX_RTV: rmux = q.rtv;
			IX_OFFL: rmux = q.off[7:0];
			IX_OFFH: rmux = {2'h0, q.off[13:8]};
			IX_AP: rmux = {3'h0, q.ap};
			IX_IP: rmux = q.ip;
			IX_SN0: rmux = SERIAL_NUMBER[7:0];
			IX_SN1: rmux = SERIAL_NUMBER[15:8];
			IX_SN2: rmux = SERIAL_NUMBER[23:16];
			IX_ONAL: rmux = q.on_a[7:0];
			IX_ONAH: rmux = {2'h0, q.on_a[13:8]};
			IX_ONBL: rmux = q.on_b[7:0];
			IX_ONBH: rmux = {2'h0, q.on_b[13:8]};
			default: rmux = 8'h00;
		endcase
	end

	//----------------------------------------------------------------
	// Next state
	//----------------------------------------------------------------

	// Bus slave, registers, status flags and the poll sequencer.
	always_comb
	begin
		logic [7:0] rclr;
		rclr = 8'h00;
		d = q;
		// Address and data are taken in either order and held.
		if (awvalid && q.awready)
		begin
			d.aw_hold = 1'b1;
			d.aw_idx = awaddr[8:2];
			d.aw_ok = mapped(awaddr);
		end
		if (wvalid && q.wready)
		begin
			d.w_hold = 1'b1;
			d.w_data = wdata[7:0];
			d.w_en = wstrb[0];
		end
		if (bvalid && bready)
			d.bvalid = 1'b0;
		if (q.aw_hold && q.w_hold && !q.bvalid)
		begin
			d.aw_hold = 1'b0;
			d.w_hold = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = q.aw_ok ? RESP_OK : RESP_ERR;
			if (q.aw_ok && q.w_en)
			begin
				case (q.aw_idx)
					IX_MODE: d.mode = {q.w_data[B_DUAL], q.w_data[B_SPEN]};
					IX_CTRL: d.pol = q.w_data[B_POL];
					IX_MASK: d.mask = q.w_data;
					IX_PCTL: d.pctl = q.w_data[3:0];
					IX_RTV: d.rtv = q.w_data;
					IX_OFFL: d.off[7:0] = q.w_data;
					IX_OFFH: d.off[13:8] = q.w_data[5:0];
					IX_AP: d.ap = q.w_data[4:0];
					IX_IP: d.ip = q.w_data;
					IX_ONAL: d.on_a[7:0] = q.w_data;
					IX_ONAH: d.on_a[13:8] = q.w_data[5:0];
					IX_ONBL: d.on_b[7:0] = q.w_data;
					IX_ONBH: d.on_b[13:8] = q.w_data[5:0];
					default: d.mode = q.mode;
				endcase
			end
		end
		// Reads answer one cycle after the address is taken.
		if (rvalid && rready)
			d.rvalid = 1'b0;
		if (arvalid && q.arready)
		begin
			d.rvalid = 1'b1;
			d.rdata = rmux;
			d.rresp = mapped(araddr) ? RESP_OK : RESP_ERR;
			if (mapped(araddr) && ar_ix == IX_STAT)
				rclr = q.status;
		end
		// A new event wins over a read clear in the same cycle.
		d.status = (q.status & ~rclr) | events;
		// Reference prescaler and divider run only while polling.
		if (q.st == ST_ON || q.st == ST_OFF)
		begin
			d.pre = q.pre + 6'h01;
			if (pre_tick)
				d.refc = (q.refc == 8'h00) ? q.rtv - 8'h01 : q.refc - 8'h01;
		end
		case (q.st)
			ST_IDLE:
			begin
				if (spen)
				begin
					d.st = ST_ON;
					d.cfg_b = 1'b0;
					d.pre = 6'h00;
					d.refc = q.rtv - 8'h01;
					d.tcnt = on_load(q, 1'b0);
					d.idle = 1'b0;
					d.aic = (q.ap == 5'h00) ? 8'hFF : {3'h0, q.ap - 5'h01};
				end
			end
			ST_ON:
			begin
				if (wake_found)
				begin
					d.st = ST_RUN;
					d.chan = wake_chan;
				end
				else if (rt)
				begin
					if (q.tcnt == 14'h0000)
					begin
						d.st = ST_OFF;
						d.tcnt = q.off - 14'h0001;
					end
					else
						d.tcnt = q.tcnt - 14'h0001;
					if (q.pctl[B_AIEN])
					begin
						if (q.aic == 8'h00)
						begin
							d.idle = !q.idle;
							if (q.idle)
								d.aic = (q.ap == 5'h00) ? 8'hFF : {3'h0, q.ap - 5'h01};
							else
								d.aic = q.ip - 8'h01;
						end
						else
							d.aic = q.aic - 8'h01;
					end
				end
			end
			ST_OFF:
			begin
				if (rt && q.tcnt == 14'h0000)
				begin
					d.st = ST_ON;
					d.cfg_b = q.mode[1] && !q.cfg_b;
					d.tcnt = on_load(q, q.mode[1] && !q.cfg_b);
					d.idle = 1'b0;
					d.aic = (q.ap == 5'h00) ? 8'hFF : {3'h0, q.ap - 5'h01};
				end
				else if (rt)
					d.tcnt = q.tcnt - 14'h0001;
			end
			ST_RUN:
				d.st = ST_RUN;
			default:
				d.st = ST_IDLE;
		endcase
		// Leaving self polling stops everything; counts restart on entry.
		if (!spen)
			d.st = ST_IDLE;
		// Registered outputs.
		d.awready = !d.aw_hold && !d.bvalid;
		d.wready = !d.w_hold && !d.bvalid;
		d.arready = !d.rvalid;
		d.irq_pin = q.pol ~^ (|(q.status & ~q.mask));
		d.rx_on = (d.st == ST_RUN) ||
			(d.st == ST_ON && !(d.pctl[B_AIEN] && d.idle));
		d.search = (d.st == ST_ON) &&
			(d.pctl[B_PERM] || !(d.pctl[B_AIEN] && d.idle));
		d.fastfb = (d.pctl[1:0] == SEL_FFB) ||
			(d.pctl[1:0] == SEL_MIX && d.cfg_b);
	end

	//----------------------------------------------------------------
	// Registers
	//----------------------------------------------------------------

	// Synchronous reset; all flags read as set after any reset.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.st <= ST_IDLE;
			q.status <= RST_STAT;
			q.rtv <= RST_RTV;
			q.off <= {6'h00, RST_OFFL};
			q.ap <= RST_AP;
			q.ip <= RST_IP;
			q.on_a <= {6'h00, RST_ONL};
			q.on_b <= {6'h00, RST_ONL};
			q.irq_pin <= 1'b1;
		end
		else
			q <= d;
	end

	assign awready = q.awready;
	assign wready = q.wready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.arready;
	assign rvalid = q.rvalid;
	assign rdata = {24'h000000, q.rdata};
	assign rresp = q.rresp;
	assign interrupt_out_pin = q.irq_pin;
	assign rx_on = q.rx_on;
	assign wake_search = q.search;
	assign fast_fallback = q.fastfb;
	assign active_config_b = q.cfg_b;

	//----------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Reset is released by the edge that also loads the pin, so attempts wait for it.
	property p_irq;
		aresetn |=> interrupt_out_pin == ($past(q.pol) ~^ |($past(q.status) & ~$past(q.mask)));
	endproperty
	a_irq: assert property (p_irq) else $error("irq pin wrong");

	property p_evt;
		events[7] ##0 events[0] |=> q.status[7] && q.status[0];
	endproperty
	a_evt: assert property (p_evt) else $error("event lost");

	property p_rst;
		!$past(aresetn) |-> q.status == RST_STAT;
	endproperty
	a_rst: assert property (p_rst) else $error("status not set");

	property p_chan;
		q.st == ST_ON && wake_found && spen |=> q.chan == $past(wake_chan);
	endproperty
	a_chan: assert property (p_chan) else $error("channel stale");

	property p_ref;
		q.st == ST_ON && pre_tick && q.refc == 8'h00 && spen |=> q.refc == $past(q.rtv) - 8'h01;
	endproperty
	a_ref: assert property (p_ref) else $error("ref reload");

	property p_off;
		q.st == ST_ON && rt && q.tcnt == 14'h0000 && !wake_found && spen
			|=> q.st == ST_OFF && q.tcnt == $past(q.off) - 14'h0001;
	endproperty
	a_off: assert property (p_off) else $error("off load");

	property p_perm;
		q.st == ST_ON && q.pctl[B_PERM] |-> wake_search;
	endproperty
	a_perm: assert property (p_perm) else $error("search dropped");

	property p_sel;
		##1 fast_fallback == (q.pctl[1:0] == SEL_FFB || (q.pctl[1:0] == SEL_MIX && q.cfg_b));
	endproperty
	a_sel: assert property (p_sel) else $error("select wrong");

	property p_exit;
		!spen |=> q.st == ST_IDLE && !rx_on;
	endproperty
	a_exit: assert property (p_exit) else $error("no stop");

	c_wake: cover property (q.st == ST_ON ##1 q.st == ST_RUN);
	c_off: cover property (q.st == ST_OFF ##1 q.st == ST_ON);
	c_irq: cover property ($changed(interrupt_out_pin));
endmodule : spt_top

/* File: tb/spt_host.sv */
// Host controller model that reaches the block over the register bus.
`timescale 1ns/1ns

module spt_host (
	// Clock.
	input wire logic aclk,
	// Write channels.
	output logic [11:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels.
	output logic [11:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// The bus sits idle until the first task call.
	initial
	begin
		{awaddr, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
		wdata = 32'h0;
		wstrb = 4'hF;
	end

	// Address and data are offered together; each drops only once taken.
	task automatic wr(input logic [6:0] ix, input logic [7:0] v, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= {3'h0, ix, 2'h0};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	// A read waits for the answer as long as it takes; the bench watchdog cuts hangs.
	task automatic rd(input logic [6:0] ix, output logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= {3'h0, ix, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
	endtask : rd
endmodule : spt_host

/* File: tb/spt_top_tb.sv */
// Self-checking testbench of the self polling timer block.
`timescale 1ns/1ns

module spt_top_tb import spt_pkg::*; ;
	localparam logic [23:0] SN = 24'h5A3C96; // Arbitrary value.
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, wake_found;
	logic interrupt_out_pin, rx_on, wake_search, fast_fallback, active_config_b;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, wake_chan;
	logic [7:0] events;
	int errors = 0;
	int total_checks = 0;

	spt_host h (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready);

	spt_top #(.SERIAL_NUMBER(SN)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .events, .wake_found, .wake_chan,
		.interrupt_out_pin, .rx_on, .wake_search, .fast_fallback, .active_config_b);

	//----------------------------------------
	// Helpers
	//----------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			errors++;
			$display("Error %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("Checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic wr(input logic [6:0] ix, input logic [7:0] v);
		logic [1:0] r;
		h.wr(ix, v, r);
	endtask : wr

	task automatic rdc(input logic [6:0] ix, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		h.rd(ix, d, r);
		chk($sformatf("reg %0h", ix), {24'h0, d}, {24'h0, e});
	endtask : rdc

	// Events are one-cycle pulses; the pin settles two edges later.
	task automatic pulse(input logic [7:0] v);
		@(posedge aclk);
		events <= v;
		@(posedge aclk);
		events <= 8'h00;
		repeat (3) @(posedge aclk);
	endtask : pulse

	// Lengths of one high run of rx_on and of the low run after it.
	task automatic runs(output int hi, output int lo);
		hi = 0;
		lo = 0;
		wait (rx_on === 1'b1);
		while (rx_on === 1'b1)
		begin
			@(posedge aclk);
			#1;
			hi++;
		end
		while (rx_on === 1'b0)
		begin
			@(posedge aclk);
			#1;
			lo++;
		end
	endtask : runs

	//----------------------------------------
	// Scenarios
	//----------------------------------------
	task automatic t_reset();
		chk("pin", interrupt_out_pin, 0);
		rdc(IX_MASK, 8'h00);
		rdc(IX_CHAN, 8'h00);
		rdc(IX_PCTL, 8'h00);
		rdc(IX_RTV, 8'h01);
		rdc(IX_OFFL, 8'h07);
		rdc(IX_OFFH, 8'h00);
		rdc(IX_AP, 8'h01);
		rdc(IX_IP, 8'h01);
		rdc(IX_STAT, 8'hFF);
		repeat (3) @(posedge aclk);
		chk("pin", interrupt_out_pin, 1);
	endtask : t_reset

	task automatic t_serial();
		logic [7:0] d;
		logic [1:0] r;
		wr(IX_SN0, 8'hAA);
		rdc(IX_SN0, SN[7:0]);
		rdc(IX_SN1, SN[15:8]);
		rdc(IX_SN2, SN[23:16]);
		h.rd(7'h7F, d, r);
		chk("rresp", r, RESP_ERR);
		h.wr(7'h7F, 8'h01, r);
		chk("bresp", r, RESP_ERR);
	endtask : t_serial

	// Each event alone: masked keeps pin quiet but still records, unmasked fires.
	task automatic t_irq();
		logic [7:0] m;
		for (int k = 0; k < 8; k++)
		begin
			m = 8'h01 << k;
			wr(IX_MASK, m);
			pulse(m);
			chk("pin", interrupt_out_pin, 1);
			rdc(IX_STAT, m);
			wr(IX_MASK, ~m);
			pulse(m);
			chk("pin", interrupt_out_pin, 0);
			rdc(IX_STAT, m);
		end
		wr(IX_MASK, 8'h00);
		wr(IX_CTRL, 8'h20);
		pulse(8'h10);
		chk("pin", interrupt_out_pin, 1);
		rdc(IX_STAT, 8'h10);
		repeat (3) @(posedge aclk);
		chk("pin", interrupt_out_pin, 0);
		wr(IX_CTRL, 8'h00);
		wr(IX_MASK, 8'h81);
		pulse(8'h81);
		chk("pin", interrupt_out_pin, 1);
		rdc(IX_MASK, 8'h81);
		rdc(IX_STAT, 8'h81);
		wr(IX_MASK, 8'h00);
	endtask : t_irq

	task automatic t_timing();
		int hi, lo;
		wr(IX_OFFL, 8'h00);
		wr(IX_OFFH, 8'h01);
		wr(IX_ONAL, 8'h02);
		wr(IX_MODE, 8'h01);
		runs(hi, lo);
		chk("on", hi, 128);
		chk("off", lo, 16384);
		wr(IX_MODE, 8'h00);
		wr(IX_RTV, 8'h00);
		wr(IX_OFFL, 8'h01);
		wr(IX_OFFH, 8'h00);
		wr(IX_ONAL, 8'h01);
		wr(IX_MODE, 8'h01);
		runs(hi, lo);
		chk("on", hi, 16384);
		chk("off", lo, 16384);
		wr(IX_MODE, 8'h00);
		wr(IX_RTV, 8'h01);
		wr(IX_ONAL, 8'h08);
		wr(IX_AP, 8'h02);
		wr(IX_IP, 8'h03);
		wr(IX_PCTL, 8'h04);
		wr(IX_MODE, 8'h01);
		runs(hi, lo);
		chk("active", hi, 128);
		chk("idle", lo, 192);
		wr(IX_MODE, 8'h00);
		wr(IX_PCTL, 8'h0C);
		wr(IX_MODE, 8'h01);
		wait (rx_on === 1'b1);
		wait (rx_on === 1'b0);
		@(posedge aclk);
		#1;
		chk("search", wake_search, 1);
	endtask : t_timing

	task automatic t_wake();
		for (int c = 2; c > 0; c--)
		begin
			wr(IX_MODE, 8'h00);
			wr(IX_PCTL, 8'h00);
			wr(IX_MODE, 8'h01);
			wait (rx_on === 1'b1);
			@(posedge aclk);
			wake_found <= 1'b1;
			wake_chan <= 2'(c);
			@(posedge aclk);
			wake_found <= 1'b0;
			wake_chan <= 2'h0;
			rdc(IX_CHAN, 8'(c));
			chk("run", rx_on, 1);
		end
	endtask : t_wake

	task automatic t_sel();
		int hi, lo;
		for (int s = 0; s < 3; s++)
		begin
			wr(IX_MODE, 8'h00);
			wr(IX_PCTL, 8'(s));
			wr(IX_MODE, 8'h01);
			wait (rx_on === 1'b1);
			@(posedge aclk);
			#1;
			chk("fallback", fast_fallback, 32'(s == 1));
		end
		// Mixed select with both configurations: A runs eight ticks, B three.
		wr(IX_MODE, 8'h00);
		wr(IX_ONBL, 8'h03);
		wr(IX_MODE, 8'h05);
		runs(hi, lo);
		chk("on a", hi, 512);
		chk("off", lo, 64);
		chk("config b", active_config_b, 1);
		chk("fallback b", fast_fallback, 1);
		runs(hi, lo);
		chk("on b", hi, 192);
		chk("config a", active_config_b, 0);
		chk("fallback a", fast_fallback, 0);
		wr(IX_MODE, 8'h00);
	endtask : t_sel

	//----------------------------------------
	// Clock, reset, sequence and watchdog
	//----------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// Main sequence: reset for 16 cycles, then every scenario in turn.
	initial
	begin
		aresetn = 1'b0;
		events = 8'h00;
		wake_found = 1'b0;
		wake_chan = 2'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset();
		t_serial();
		t_irq();
		t_timing();
		t_wake();
		t_sel();
		tally_and_finish();
	end

	// The whole run needs about 52000 cycles; the limit leaves a fair margin.
	initial
	begin
		repeat (90000) @(posedge aclk);
		errors++;
		tally_and_finish();
	end
endmodule : spt_top_tb
